// >>> hdl/symts_cmp.v
`timescale 1ns/100ps
`default_nettype none
`include "symts_regs.vh"

// one compare unit: one pulse per arrival of the count at its target
module symts_cmp
#(
    parameter W = 32
)
(
    input wire clk_sys,
    input wire sys_rst,
    input wire run,
    input wire [W-1:0] count,
    input wire [W-1:0] beacon_stamp,
    input wire [W-1:0] tx_frame_stamp,
    input wire [W-1:0] rx_frame_stamp,
    input wire [1:0] base_select,
    input wire relative_mode,
    input wire [W-1:0] value,
    output reg match
);

reg [W-1:0] base;
wire [W-1:0] target;
wire equal;
reg equal_ff;

always @*
begin
    case (base_select) // R1
        `SYMTS_SRC_TX: base = tx_frame_stamp;
        `SYMTS_SRC_RX: base = rx_frame_stamp;
        default: base = beacon_stamp;
    endcase
end

// the sum wraps like the counter itself
assign target = relative_mode ? (base + value) : value; // R10
assign equal = (count == target);

// edge of equality, so a count parked at the target fires only once
always @(posedge clk_sys)
begin
    if (sys_rst)
    begin
        equal_ff <= 1'b0;
        match <= 1'b0;
    end
    else
    begin
        equal_ff <= equal;
        match <= run & equal & ~equal_ff; // R10
    end
end

endmodule // symts_cmp

`default_nettype wire

// >>> hdl/symts_regs.vh
`ifndef SYMTS_REGS_VH
`define SYMTS_REGS_VH

// register offsets on the byte-wide register port
`define SYMTS_CMP_SRC_OFS 8'hdb
`define SYMTS_CTRL_OFS 8'hdc
`define SYMTS_CNT_B0_OFS 8'he1
`define SYMTS_CNT_B1_OFS 8'he2
`define SYMTS_CNT_B2_OFS 8'he3
`define SYMTS_CNT_B3_OFS 8'he4
`define SYMTS_BCN_B0_OFS 8'he5
`define SYMTS_BCN_B1_OFS 8'he6
`define SYMTS_BCN_B2_OFS 8'he7
`define SYMTS_BCN_B3_OFS 8'he8
`define SYMTS_SFD_B0_OFS 8'he9
`define SYMTS_SFD_B1_OFS 8'hea
`define SYMTS_SFD_B2_OFS 8'heb
`define SYMTS_SFD_B3_OFS 8'hec
`define SYMTS_IRQ_STAT_OFS 8'hf0
`define SYMTS_IRQ_CLR_OFS 8'hf1
`define SYMTS_IRQ_EN_OFS 8'hf2
`define SYMTS_NET_LO_OFS 8'hf3
`define SYMTS_NET_HI_OFS 8'hf4
`define SYMTS_CMP1_B0_OFS 8'hf5
`define SYMTS_CMP1_B1_OFS 8'hf6
`define SYMTS_CMP1_B2_OFS 8'hf7
`define SYMTS_CMP1_B3_OFS 8'hf8
`define SYMTS_TX_B0_OFS 8'hf9
`define SYMTS_TX_B1_OFS 8'hfa
`define SYMTS_TX_B2_OFS 8'hfb
`define SYMTS_TX_B3_OFS 8'hfc
`define SYMTS_RX_B0_OFS 8'hd7
`define SYMTS_RX_B1_OFS 8'hd8
`define SYMTS_RX_B2_OFS 8'hd9
`define SYMTS_RX_B3_OFS 8'hda

// control register fields
`define SYMTS_CTRL_REL1_BIT 0
`define SYMTS_CTRL_AUTO_BIT 3
`define SYMTS_CTRL_EN_BIT 5
`define SYMTS_CTRL_MBTS_BIT 6
`define SYMTS_CTRL_MASK 8'h29

// compare source field and its codes
`define SYMTS_SRC1_MSB 1
`define SYMTS_SRC1_LSB 0
`define SYMTS_SRC_BEACON 2'h0
`define SYMTS_SRC_TX 2'h1
`define SYMTS_SRC_RX 2'h2

// interrupt event bits
`define SYMTS_EV_CMP1 0
`define SYMTS_EV_BEACON 1
`define SYMTS_EV_RX 2
`define SYMTS_EV_TX 3
`define SYMTS_EV_NUM 4

// reset values
`define SYMTS_STAMP_RST 32'h0000_0000
`define SYMTS_BYTE_RST 8'h00
`define SYMTS_NET_RST 8'hff
`define SYMTS_NET_WILD 16'hffff

// timing
`define SYMTS_SYMBOL_NS 16000
`define SYMTS_CLK_NS 20

`endif

// >>> hdl/symts_top.v
// Implementation choice: the strobed register port.
`timescale 1ns/100ps
`default_nettype none
`include "symts_regs.vh"

// Contract
// R1 - compare unit one base: 0 beacon stamp (default), 1 transmit, 2 received stamp
// R2 - symbol count is 32 bits, four byte registers, high byte to low
// R3 - SFD stamp: 32 bits, read-only, four bytes, zero after reset
// R4 - transmit stamp takes the count one symbol before preamble; read-only
// R5 - software adds eleven symbols to transmit stamps before comparing with SFD stamps
// R6 - received stamp loads from SFD stamp on good FCS only
// R7 - with auto modes and address filtering, received stamp also needs address match
// R8 - beacon stamp loads from SFD stamp on valid beacon with matching or wildcard network
// R9 - compare value one: 32 bits, read/write, four bytes, zero after reset
// R10 - relative mode matches count against stamp plus value, else value alone
// R11 - automatic SFD and beacon stamping only while auto stamp enable is set
// R12 - manual beacon stamp bit copies count into beacon stamp, then clears
module symts_top
#(
    parameter SYM_CYCLES = (`SYMTS_SYMBOL_NS + `SYMTS_CLK_NS - 1) / `SYMTS_CLK_NS
)
(
    input wire clk_sys,
    input wire sys_rst,
    input wire [7:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [7:0] reg_rdata,
    output reg irq,
    output reg cmp1_match,
    input wire sfd_detect,
    input wire tx_lead,
    input wire rx_end,
    input wire rx_fcs_ok,
    input wire rx_addr_match,
    input wire rx_is_beacon,
    input wire [15:0] rx_src_ident,
    input wire auto_mode_en,
    input wire addr_filter_en
);

reg [31:0] div_cnt_ff;
reg sym_tick_ff;
reg [31:0] symbol_count_ff;
reg [31:0] sfd_stamp_ff;
reg [31:0] tx_frame_stamp_ff;
reg [31:0] rx_frame_stamp_ff;
reg [31:0] beacon_stamp_ff;
reg [31:0] compare1_value_ff;
reg [1:0] cmp1_base_select_ff;
reg cmp1_relative_mode_ff;
reg auto_stamp_enable_ff;
reg count_enable_ff;
reg manual_beacon_stamp_ff;
reg [7:0] network_ident_low_ff;
reg [7:0] network_ident_high_ff;
reg [`SYMTS_EV_NUM-1:0] irq_status_ff;
reg [`SYMTS_EV_NUM-1:0] irq_enable_ff;
reg [`SYMTS_EV_NUM-1:0] nxt_irq_status;
reg [7:0] nxt_rdata;
wire cmp1_hit;
wire wr_cnt;
wire rx_take;
wire beacon_take;
wire net_ok;
wire [15:0] network_ident;
wire wr_irq_clr;
wire wr_irq_en;
reg [`SYMTS_EV_NUM-1:0] nxt_irq_enable;

assign wr_cnt = reg_wr & count_enable_ff;
assign network_ident = {network_ident_high_ff, network_ident_low_ff};
assign wr_irq_clr = reg_wr & (reg_addr == `SYMTS_IRQ_CLR_OFS);
assign wr_irq_en = reg_wr & (reg_addr == `SYMTS_IRQ_EN_OFS);
assign net_ok = (rx_src_ident == network_ident) | (network_ident == `SYMTS_NET_WILD);
assign rx_take = rx_end & rx_fcs_ok // R6
    & (~(auto_mode_en & addr_filter_en) | rx_addr_match); // R7
assign beacon_take = rx_end & rx_fcs_ok & rx_is_beacon & net_ok // R8
    & auto_stamp_enable_ff; // R11

// symbol rate enable; the divider restarts while the counter is off
always @(posedge clk_sys)
begin
    if (sys_rst)
    begin
        div_cnt_ff <= 32'h0000_0000;
        sym_tick_ff <= 1'b0;
    end
    else if (!count_enable_ff)
    begin
        div_cnt_ff <= 32'h0000_0000;
        sym_tick_ff <= 1'b0;
    end
    else if (div_cnt_ff == SYM_CYCLES - 1)
    begin
        div_cnt_ff <= 32'h0000_0000;
        sym_tick_ff <= 1'b1;
    end
    else
    begin
        div_cnt_ff <= div_cnt_ff + 32'h0000_0001;
        sym_tick_ff <= 1'b0;
    end
end

// bytes are not latched together, so a read across a tick may tear
// a byte write wins over the tick of the same cycle; writes are lost while disabled
always @(posedge clk_sys)
begin
    if (sys_rst)
        symbol_count_ff <= `SYMTS_STAMP_RST;
    else if (wr_cnt && reg_addr == `SYMTS_CNT_B3_OFS)
        symbol_count_ff[31:24] <= reg_wdata; // R2
    else if (wr_cnt && reg_addr == `SYMTS_CNT_B2_OFS)
        symbol_count_ff[23:16] <= reg_wdata; // R2
    else if (wr_cnt && reg_addr == `SYMTS_CNT_B1_OFS)
        symbol_count_ff[15:8] <= reg_wdata; // R2
    else if (wr_cnt && reg_addr == `SYMTS_CNT_B0_OFS)
        symbol_count_ff[7:0] <= reg_wdata; // R2
    else if (sym_tick_ff)
        symbol_count_ff <= symbol_count_ff + 32'h0000_0001; // R2
end

// stamps; one process each keeps the capture conditions apart
always @(posedge clk_sys)
begin
    if (sys_rst)
        sfd_stamp_ff <= `SYMTS_STAMP_RST; // R3
    else if (sfd_detect && auto_stamp_enable_ff) // R11
        sfd_stamp_ff <= symbol_count_ff; // R3
end

// the radio raises tx_lead one symbol ahead of the preamble
always @(posedge clk_sys)
begin
    if (sys_rst)
        tx_frame_stamp_ff <= `SYMTS_STAMP_RST;
    else if (tx_lead)
        tx_frame_stamp_ff <= symbol_count_ff; // R4
end

// an SFD in the same cycle as a frame end is not yet seen here
always @(posedge clk_sys)
begin
    if (sys_rst)
        rx_frame_stamp_ff <= `SYMTS_STAMP_RST;
    else if (rx_take)
        rx_frame_stamp_ff <= sfd_stamp_ff; // R6
end

// manual stamping wins over a beacon ending in the same cycle
always @(posedge clk_sys)
begin
    if (sys_rst)
        beacon_stamp_ff <= `SYMTS_STAMP_RST;
    else if (manual_beacon_stamp_ff)
        beacon_stamp_ff <= symbol_count_ff; // R12
    else if (beacon_take)
        beacon_stamp_ff <= sfd_stamp_ff; // R8
end

// compare value one, byte by byte
always @(posedge clk_sys)
begin
    if (sys_rst)
        compare1_value_ff <= `SYMTS_STAMP_RST; // R9
    else if (reg_wr)
    begin
        case (reg_addr)
            `SYMTS_CMP1_B3_OFS: compare1_value_ff[31:24] <= reg_wdata; // R9
            `SYMTS_CMP1_B2_OFS: compare1_value_ff[23:16] <= reg_wdata; // R9
            `SYMTS_CMP1_B1_OFS: compare1_value_ff[15:8] <= reg_wdata; // R9
            `SYMTS_CMP1_B0_OFS: compare1_value_ff[7:0] <= reg_wdata; // R9
            default:
            begin
            end
        endcase
    end
end

// software written configuration
always @(posedge clk_sys)
begin
    if (sys_rst)
    begin
        cmp1_base_select_ff <= `SYMTS_SRC_BEACON; // R1
        cmp1_relative_mode_ff <= 1'b0;
        auto_stamp_enable_ff <= 1'b0;
        count_enable_ff <= 1'b0;
        manual_beacon_stamp_ff <= 1'b0;
        network_ident_low_ff <= `SYMTS_NET_RST;
        network_ident_high_ff <= `SYMTS_NET_RST;
    end
    else
    begin
        // held one cycle, so a write of one is seen and then cleared
        manual_beacon_stamp_ff <= 1'b0; // R12
        if (reg_wr)
        begin
            case (reg_addr)
                `SYMTS_CMP_SRC_OFS:
                    cmp1_base_select_ff <=
                        reg_wdata[`SYMTS_SRC1_MSB:`SYMTS_SRC1_LSB]; // R1
                `SYMTS_CTRL_OFS:
                begin
                    cmp1_relative_mode_ff <= reg_wdata[`SYMTS_CTRL_REL1_BIT]; // R10
                    auto_stamp_enable_ff <= reg_wdata[`SYMTS_CTRL_AUTO_BIT]; // R11
                    count_enable_ff <= reg_wdata[`SYMTS_CTRL_EN_BIT];
                    manual_beacon_stamp_ff <= reg_wdata[`SYMTS_CTRL_MBTS_BIT]; // R12
                end
                `SYMTS_NET_LO_OFS: network_ident_low_ff <= reg_wdata;
                `SYMTS_NET_HI_OFS: network_ident_high_ff <= reg_wdata;
                default:
                begin
                end
            endcase
        end
    end
end

symts_cmp
#(
    .W(32)
)
u_cmp1
(
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .run(count_enable_ff),
    .count(symbol_count_ff),
    .beacon_stamp(beacon_stamp_ff),
    .tx_frame_stamp(tx_frame_stamp_ff),
    .rx_frame_stamp(rx_frame_stamp_ff),
    .base_select(cmp1_base_select_ff),
    .relative_mode(cmp1_relative_mode_ff),
    .value(compare1_value_ff),
    .match(cmp1_hit)
);

// enable writes reach irq in the cycle they land, as a clear does
always @*
begin
    nxt_irq_enable = irq_enable_ff;
    if (wr_irq_en)
        nxt_irq_enable = reg_wdata[`SYMTS_EV_NUM-1:0];
end

// sticky events; a new event beats a clear in the same cycle
always @*
begin
    nxt_irq_status = irq_status_ff;
    if (wr_irq_clr)
        nxt_irq_status = irq_status_ff & ~reg_wdata[`SYMTS_EV_NUM-1:0];
    if (cmp1_hit)
        nxt_irq_status[`SYMTS_EV_CMP1] = 1'b1;
    if (manual_beacon_stamp_ff || beacon_take)
        nxt_irq_status[`SYMTS_EV_BEACON] = 1'b1;
    if (rx_take)
        nxt_irq_status[`SYMTS_EV_RX] = 1'b1;
    if (tx_lead)
        nxt_irq_status[`SYMTS_EV_TX] = 1'b1;
end

always @(posedge clk_sys)
begin
    if (sys_rst)
    begin
        irq_status_ff <= {`SYMTS_EV_NUM{1'b0}};
        irq_enable_ff <= {`SYMTS_EV_NUM{1'b0}};
        irq <= 1'b0;
        cmp1_match <= 1'b0;
    end
    else
    begin
        irq_status_ff <= nxt_irq_status;
        irq_enable_ff <= nxt_irq_enable;
        // irq follows the next status and enable, so it rises with the status bit
        irq <= |(nxt_irq_status & nxt_irq_enable);
        cmp1_match <= cmp1_hit;
    end
end

// read mux; unmapped and write-only addresses read zero
always @*
begin
    nxt_rdata = `SYMTS_BYTE_RST;
    case (reg_addr)
        `SYMTS_CNT_B3_OFS: nxt_rdata = symbol_count_ff[31:24]; // R2
        `SYMTS_CNT_B2_OFS: nxt_rdata = symbol_count_ff[23:16]; // R2
        `SYMTS_CNT_B1_OFS: nxt_rdata = symbol_count_ff[15:8]; // R2
        `SYMTS_CNT_B0_OFS: nxt_rdata = symbol_count_ff[7:0]; // R2
        `SYMTS_SFD_B3_OFS: nxt_rdata = sfd_stamp_ff[31:24]; // R3
        `SYMTS_SFD_B2_OFS: nxt_rdata = sfd_stamp_ff[23:16]; // R3
        `SYMTS_SFD_B1_OFS: nxt_rdata = sfd_stamp_ff[15:8]; // R3
        `SYMTS_SFD_B0_OFS: nxt_rdata = sfd_stamp_ff[7:0]; // R3
        `SYMTS_TX_B3_OFS: nxt_rdata = tx_frame_stamp_ff[31:24]; // R4
        `SYMTS_TX_B2_OFS: nxt_rdata = tx_frame_stamp_ff[23:16]; // R4
        `SYMTS_TX_B1_OFS: nxt_rdata = tx_frame_stamp_ff[15:8]; // R4
        `SYMTS_TX_B0_OFS: nxt_rdata = tx_frame_stamp_ff[7:0]; // R4
        `SYMTS_RX_B3_OFS: nxt_rdata = rx_frame_stamp_ff[31:24];
        `SYMTS_RX_B2_OFS: nxt_rdata = rx_frame_stamp_ff[23:16];
        `SYMTS_RX_B1_OFS: nxt_rdata = rx_frame_stamp_ff[15:8];
        `SYMTS_RX_B0_OFS: nxt_rdata = rx_frame_stamp_ff[7:0];
        `SYMTS_BCN_B3_OFS: nxt_rdata = beacon_stamp_ff[31:24];
        `SYMTS_BCN_B2_OFS: nxt_rdata = beacon_stamp_ff[23:16];
        `SYMTS_BCN_B1_OFS: nxt_rdata = beacon_stamp_ff[15:8];
        `SYMTS_BCN_B0_OFS: nxt_rdata = beacon_stamp_ff[7:0];
        `SYMTS_CMP1_B3_OFS: nxt_rdata = compare1_value_ff[31:24]; // R9
        `SYMTS_CMP1_B2_OFS: nxt_rdata = compare1_value_ff[23:16]; // R9
        `SYMTS_CMP1_B1_OFS: nxt_rdata = compare1_value_ff[15:8]; // R9
        `SYMTS_CMP1_B0_OFS: nxt_rdata = compare1_value_ff[7:0]; // R9
        `SYMTS_CMP_SRC_OFS: nxt_rdata = {6'h00, cmp1_base_select_ff};
        `SYMTS_CTRL_OFS:
        begin
            nxt_rdata[`SYMTS_CTRL_REL1_BIT] = cmp1_relative_mode_ff;
            nxt_rdata[`SYMTS_CTRL_AUTO_BIT] = auto_stamp_enable_ff;
            nxt_rdata[`SYMTS_CTRL_EN_BIT] = count_enable_ff;
            nxt_rdata[`SYMTS_CTRL_MBTS_BIT] = manual_beacon_stamp_ff;
        end
        `SYMTS_NET_LO_OFS: nxt_rdata = network_ident_low_ff;
        `SYMTS_NET_HI_OFS: nxt_rdata = network_ident_high_ff;
        `SYMTS_IRQ_STAT_OFS: nxt_rdata = {4'h0, irq_status_ff};
        `SYMTS_IRQ_EN_OFS: nxt_rdata = {4'h0, irq_enable_ff};
        default: nxt_rdata = `SYMTS_BYTE_RST;
    endcase
end

// data stands only in the cycle after the strobe
always @(posedge clk_sys)
begin
    if (sys_rst)
        reg_rdata <= `SYMTS_BYTE_RST;
    else if (reg_rd)
        reg_rdata <= nxt_rdata;
    else
        reg_rdata <= `SYMTS_BYTE_RST;
end

endmodule // symts_top

`default_nettype wire

// >>> testbench/symts_chk_sva.sv
`timescale 1ns/100ps
`default_nettype none
`include "symts_regs.vh"
module symts_chk (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic cmp1_match,
    input wire logic sfd_detect
);
    reg [31:0] cmp_ff;
    reg [15:0] net_ff;
    reg [1:0] src_ff;
    reg en_ff;
    reg sfd_ff;
    wire [7:0] idx = reg_addr - 8'hf5;
    wire [31:0] cmp_sh = cmp_ff >> {idx[1:0], 3'h0};
    // shadows of compare value one, network ident, compare source and count enable, rebuilt from the port traffic, and a sticky flag of any SFD seen
    always @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            cmp_ff <= 32'h0;
            net_ff <= 16'hffff;
            src_ff <= 2'h0;
            en_ff <= 1'b0;
            sfd_ff <= 1'b0;
        end
        else
        begin
            if (reg_wr && idx < 8'h04)
                cmp_ff[{idx[1:0], 3'h0} +: 8] <= reg_wdata;
            if (reg_wr && reg_addr == `SYMTS_NET_LO_OFS)
                net_ff[7:0] <= reg_wdata;
            if (reg_wr && reg_addr == `SYMTS_NET_HI_OFS)
                net_ff[15:8] <= reg_wdata;
            if (reg_wr && reg_addr == `SYMTS_CMP_SRC_OFS)
                src_ff <= reg_wdata[1:0];
            if (reg_wr && reg_addr == `SYMTS_CTRL_OFS)
                en_ff <= reg_wdata[5];
            sfd_ff <= sfd_ff | sfd_detect;
        end
    end
    default clocking dcb @(posedge clk_sys);
    endclocking
    default disable iff (sys_rst);
    sequence s_mbts_set;
        reg_wr && reg_addr == `SYMTS_CTRL_OFS && reg_wdata[6];
    endsequence
    sequence s_ctrl_rd;
        reg_rd && reg_addr == `SYMTS_CTRL_OFS;
    endsequence
    a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
        else $error("read data outside its answer cycle");
    a_match_pulse: assert property (cmp1_match |=> !cmp1_match)
        else $error("compare match longer than one cycle");
    a_match_enabled: assert property (cmp1_match |-> $past(en_ff, 2))
        else $error("compare match while counter disabled");
    a_cmp_readback: assert property (reg_rd && idx < 8'h04
        |=> reg_rdata == $past(cmp_sh[7:0]))
        else $error("compare value byte reads wrong");
    a_net_readback: assert property (reg_rd && (reg_addr == 8'hf3 || reg_addr == 8'hf4)
        |=> reg_rdata == $past(reg_addr[0] ? net_ff[7:0] : net_ff[15:8]))
        else $error("network ident byte reads wrong");
    a_src_readback: assert property (reg_rd && reg_addr == `SYMTS_CMP_SRC_OFS
        |=> reg_rdata[1:0] == $past(src_ff))
        else $error("compare source reads wrong");
    a_mbts_clears: assert property (s_mbts_set ##2 s_ctrl_rd |=> !reg_rdata[6])
        else $error("manual beacon bit did not clear");
    a_sfd_reset: assert property (reg_rd && !sfd_ff && reg_addr >= 8'he9 && reg_addr <= 8'hec
        |=> reg_rdata == 8'h00)
        else $error("sfd stamp not zero before any capture");
endmodule // symts_chk
`default_nettype wire

// >>> testbench/symts_radio.sv
`timescale 1ns/100ps
`default_nettype none
module symts_radio (
    input wire logic clk_sys,
    output logic sfd_detect,
    output logic tx_lead,
    output logic rx_end,
    output logic rx_fcs_ok,
    output logic rx_addr_match,
    output logic rx_is_beacon,
    output logic [15:0] rx_src_ident
);
    initial
    begin
        {sfd_detect, tx_lead, rx_end, rx_fcs_ok, rx_addr_match, rx_is_beacon} = 6'h00;
        rx_src_ident = 16'h0000;
    end
    task automatic frame(input fcs, input am, input bcn, input [15:0] id);
        sfd_detect <= 1'b1;
        @(posedge clk_sys) sfd_detect <= 1'b0;
        repeat (2) @(posedge clk_sys);
        rx_end <= 1'b1;
        rx_fcs_ok <= fcs;
        rx_addr_match <= am;
        rx_is_beacon <= bcn;
        rx_src_ident <= id;
        @(posedge clk_sys) rx_end <= 1'b0;
        // qualifiers are stale once the end pulse is gone, so show their inverse
        rx_fcs_ok <= ~fcs;
        rx_addr_match <= ~am;
        rx_is_beacon <= ~bcn;
        rx_src_ident <= ~id;
        @(posedge clk_sys);
    endtask
    // own frame on air: its SFD is detected eleven symbols after the lead pulse
    task automatic tx_loop(input int sym);
        tx_lead <= 1'b1;
        @(posedge clk_sys) tx_lead <= 1'b0;
        repeat (11 * sym - 1) @(posedge clk_sys);
        sfd_detect <= 1'b1;
        @(posedge clk_sys) sfd_detect <= 1'b0;
        @(posedge clk_sys);
    endtask
    task automatic tx_start;
        tx_lead <= 1'b1;
        @(posedge clk_sys) tx_lead <= 1'b0;
        @(posedge clk_sys);
    endtask
endmodule // symts_radio
`default_nettype wire

// >>> testbench/testbench.sv
`timescale 1ns/100ps
`default_nettype none
`include "symts_regs.vh"
module testbench;
    logic clk_sys = 1'b0;
    logic sys_rst = 1'b1;
    logic reg_wr = 1'b0, reg_rd = 1'b0, rd_q = 1'b0, auto_mode_en = 1'b0, addr_filter_en = 1'b0;
    logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, rnd = 8'h5a, reg_rdata;
    logic irq, cmp1_match, sfd_detect, tx_lead, rx_end, rx_fcs_ok, rx_addr_match, rx_is_beacon;
    logic [15:0] rx_src_ident;
    logic [23:0] up;
    logic [31:0] exp_q[$];
    logic [31:0] bases[3];
    int fails = 0, n_compared = 0, cyc = 0, i, s;
    always #10 clk_sys = ~clk_sys;
    localparam int SYM = 64;
    symts_top #(.SYM_CYCLES(SYM)) DUT (.clk_sys, .sys_rst, .reg_addr, .reg_wdata, .reg_wr,
        .reg_rd, .reg_rdata, .irq, .cmp1_match, .sfd_detect, .tx_lead, .rx_end, .rx_fcs_ok,
        .rx_addr_match, .rx_is_beacon, .rx_src_ident, .auto_mode_en, .addr_filter_en);
    symts_radio u_radio (.clk_sys, .sfd_detect, .tx_lead, .rx_end, .rx_fcs_ok, .rx_addr_match,
        .rx_is_beacon, .rx_src_ident);
    function automatic [7:0] lfsr(input [7:0] v);
        lfsr = {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
    endfunction
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            fails++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic wr(input [7:0] a, input [7:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk_sys) reg_wr <= 1'b0;
        @(posedge clk_sys);
    endtask
    task automatic rd(input [7:0] a, input [7:0] e);
        exp_q.push_back(e);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk_sys) reg_rd <= 1'b0;
        @(posedge clk_sys);
    endtask
    task automatic rd32(input [7:0] a, input [31:0] v);
        for (int k = 3; k >= 0; k--)
            rd(a + k[7:0], v[8*k +: 8]);
    endtask
    task automatic wr32(input [7:0] a, input [31:0] v);
        for (int k = 3; k >= 0; k--)
            wr(a + k[7:0], v[8*k +: 8]);
    endtask
    // counter writes need the enable; a short enable window never reaches a tick
    task automatic set_count(input [31:0] v);
        wr(`SYMTS_CTRL_OFS, 8'h28);
        wr32(`SYMTS_CNT_B0_OFS, v);
        wr(`SYMTS_CTRL_OFS, 8'h08);
    endtask
    task automatic irq_is(input logic e);
        repeat (3) @(negedge clk_sys);
        chk("irq", irq, e);
        @(posedge clk_sys);
    endtask
    task complete_run;
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    always @(posedge clk_sys)
    begin
        if (rd_q)
            chk("reg_rdata", reg_rdata, exp_q.pop_front());
        rd_q <= reg_rd;
        cyc++;
        if (cyc == 20000)
        begin
            fails++;
            complete_run();
        end
    end
    initial
    begin
        repeat (10) @(posedge clk_sys);
        sys_rst <= 1'b0;
        for (i = 8'hd7; i <= 8'hfc; i++)
            rd(i[7:0], (i == 8'hf3 || i == 8'hf4) ? 8'hff : 8'h00);
        rd(8'h10, 8'h00);
        $display("test reset values done");
        for (i = 0; i < 4; i++)
        begin
            rnd = lfsr(rnd);
            up = {up[15:0], rnd};
        end
        wr32(`SYMTS_CMP1_B0_OFS, {up, rnd});
        rd32(`SYMTS_CMP1_B0_OFS, {up, rnd});
        wr(8'he9, 8'hff);
        wr(8'hfa, 8'hff);
        wr(8'he1, 8'hff);
        rd(8'he9, 8'h00);
        rd(8'hfa, 8'h00);
        rd(8'he1, 8'h00);
        $display("test register access done");
        set_count({up, 8'h10});
        u_radio.frame(1'b1, 1'b1, 1'b0, 16'h1234);
        u_radio.tx_start();
        rd32(`SYMTS_SFD_B0_OFS, {up, 8'h10});
        rd32(`SYMTS_RX_B0_OFS, {up, 8'h10});
        rd32(`SYMTS_TX_B0_OFS, {up, 8'h10});
        rd32(`SYMTS_CNT_B0_OFS, {up, 8'h10});
        set_count({up, 8'h20});
        u_radio.frame(1'b0, 1'b1, 1'b0, 16'h1234);
        auto_mode_en <= 1'b1;
        addr_filter_en <= 1'b1;
        u_radio.frame(1'b1, 1'b0, 1'b0, 16'h1234);
        rd32(`SYMTS_RX_B0_OFS, {up, 8'h10});
        u_radio.frame(1'b1, 1'b1, 1'b0, 16'h1234);
        rd32(`SYMTS_RX_B0_OFS, {up, 8'h20});
        set_count({up, 8'h30});
        u_radio.frame(1'b1, 1'b1, 1'b1, 16'h1234);
        rd32(`SYMTS_BCN_B0_OFS, {up, 8'h30});
        wr(`SYMTS_NET_LO_OFS, 8'h55);
        wr(`SYMTS_NET_HI_OFS, 8'h55);
        set_count({up, 8'h40});
        u_radio.frame(1'b1, 1'b1, 1'b1, 16'h1234);
        rd32(`SYMTS_BCN_B0_OFS, {up, 8'h30});
        u_radio.frame(1'b1, 1'b1, 1'b1, 16'h5555);
        rd32(`SYMTS_BCN_B0_OFS, {up, 8'h40});
        set_count({up, 8'h50});
        wr(`SYMTS_CTRL_OFS, 8'h00);
        u_radio.frame(1'b1, 1'b1, 1'b1, 16'h5555);
        rd32(`SYMTS_SFD_B0_OFS, {up, 8'h40});
        rd32(`SYMTS_BCN_B0_OFS, {up, 8'h40});
        wr(`SYMTS_CTRL_OFS, 8'h40);
        rd(`SYMTS_CTRL_OFS, 8'h00);
        rd32(`SYMTS_BCN_B0_OFS, {up, 8'h50});
        $display("test stamps done");
        wr(`SYMTS_IRQ_CLR_OFS, 8'hff);
        rd(`SYMTS_IRQ_STAT_OFS, 8'h00);
        wr(`SYMTS_IRQ_EN_OFS, 8'h04);
        u_radio.frame(1'b1, 1'b1, 1'b0, 16'h5555);
        irq_is(1'b1);
        rd(`SYMTS_IRQ_STAT_OFS, 8'h04);
        wr(`SYMTS_IRQ_CLR_OFS, 8'h04);
        irq_is(1'b0);
        wr(`SYMTS_IRQ_EN_OFS, 8'h00);
        u_radio.frame(1'b1, 1'b1, 1'b0, 16'h5555);
        irq_is(1'b0);
        rd(`SYMTS_IRQ_STAT_OFS, 8'h04);
        $display("test interrupt done");
        bases[0] = {up, 8'h50};
        bases[1] = {up, 8'h10};
        bases[2] = {up, 8'h40};
        for (s = 0; s < 4; s++)
        begin
            set_count({up, 8'h60});
            wr32(`SYMTS_CMP1_B0_OFS, s < 3 ? {up, 8'h62} - bases[s] : {up, 8'h62});
            wr(`SYMTS_CMP_SRC_OFS, s[7:0]);
            wr(`SYMTS_CTRL_OFS, s < 3 ? 8'h29 : 8'h28);
            for (i = 0; i < 400 && cmp1_match !== 1'b1; i++)
                @(negedge clk_sys);
            chk("cmp1_match", cmp1_match, 1'b1);
            chk("match delay", i > 100, 1'b1);
            @(posedge clk_sys);
            wr(`SYMTS_CTRL_OFS, 8'h08);
        end
        $display("test compare done");
        set_count({up, 8'h70});
        wr(`SYMTS_CTRL_OFS, 8'h28);
        u_radio.tx_loop(SYM);
        wr(`SYMTS_CTRL_OFS, 8'h08);
        rd32(`SYMTS_TX_B0_OFS, {up, 8'h70});
        rd32(`SYMTS_SFD_B0_OFS, {up, 8'h70} + 32'h0000_000b);
        $display("test own frame offset done");
        complete_run();
    end
endmodule // testbench
bind symts_top symts_chk u_chk (.clk_sys, .sys_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .cmp1_match, .sfd_detect);
`default_nettype wire
